//--- rtl/lpsw_cfg.svh
`ifndef LPSW_CFG_SVH
`define LPSW_CFG_SVH

// Clock and link rates
`define LPSW_CLK_HZ 25000000
`define LPSW_BAUD_BPS 19200
`define LPSW_TICK_MS 1
`define LPSW_MS_PER_S 1000

// Register indices; byte address is four times the index
`define LPSW_IDX_W 10
`define LPSW_ADDR_W 12
`define LPSW_IDX_ASSOC_STAT 10'h12E
`define LPSW_IDX_FREQ_SEL 10'h133
`define LPSW_IDX_LP_SELECT 10'h154
`define LPSW_IDX_PER_WAKE 10'h155
`define LPSW_IDX_IDLE_TO 10'h15E
`define LPSW_IDX_EDGE_CFG 10'h15F

// Reset values
`define LPSW_RST_LP_SELECT 8'h00
`define LPSW_RST_PER_WAKE 16'h0000
`define LPSW_RST_FREQ_SEL 8'h00
`define LPSW_RST_IDLE_TO 16'h0064
`define LPSW_RST_EDGE_CFG 2'h0

// Field positions
`define LPSW_LP_EN_BIT 0
`define LPSW_EDGE_RISE_BIT 0
`define LPSW_EDGE_FALL_BIT 1

// Association schedule, in seconds and attempts
`define LPSW_ASSOC_TRY_S 16'h0005
`define LPSW_BACKOFF_S 16'h00E1
`define LPSW_HOUR_S 16'h0E10
`define LPSW_FAIL_LIMIT 3'h5

// Wake input lockout, in ms
`define LPSW_IO_LOCK_MS 10'h3E8

`endif

//--- rtl/lpsw_pkg.sv
package lpsw_pkg;

  typedef enum logic [2:0] {
    ST_ASSOC,
    ST_BACKOFF,
    ST_STANDBY,
    ST_AWAKE,
    ST_REPORT
  } lpsw_state_e;

  typedef struct packed {
    lpsw_state_e st;
    logic wk_s1;
    logic wk_s2;
    logic io_s1;
    logic io_s2;
    logic io_d;
    logic [2:0] fails;
    logic hourly;
    logic assoc;
    logic [15:0] sec_cnt;
    logic [15:0] sec_tgt;
    logic [15:0] ms_cnt;
    logic [9:0] lock_cnt;
    logic [7:0] lp_sel;
    logic [15:0] per_wake;
    logic [7:0] freq;
    logic [15:0] idle_to;
    logic [1:0] edge_cfg;
    logic awake;
    logic rts;
    logic rpt;
    logic try_assoc;
    logic [31:0] rdata;
  } lpsw_core_s;

  typedef struct packed {
    logic [31:0] ms_div;
    logic [31:0] s_div;
    logic [31:0] baud_div;
    logic ms_tick;
    logic s_tick;
    logic baud_tick;
  } lpsw_tick_s;

endpackage : lpsw_pkg

//--- rtl/lpsw_tick.sv
`timescale 1ns/100ps
`default_nettype none
`include "lpsw_cfg.svh"

module lpsw_tick
  import lpsw_pkg::*;
#(
  parameter int MS_CYC = `LPSW_CLK_HZ / 1000 * `LPSW_TICK_MS,
  parameter int MS_PER_S = `LPSW_MS_PER_S,
  parameter int BAUD_CYC = `LPSW_CLK_HZ / `LPSW_BAUD_BPS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  output logic ms_tick,
  output logic s_tick,
  output logic baud_tick
);

  lpsw_tick_s r, n;

  always_comb begin
    n = r;
    n.ms_tick = 1'b0;
    n.s_tick = 1'b0;
    n.baud_tick = 1'b0;
    // Fixed divider, the link rate has no register
    if (r.baud_div == 32'(BAUD_CYC - 1)) begin
      n.baud_div = '0;
      n.baud_tick = 1'b1;
    end else begin
      n.baud_div = r.baud_div + 32'h1;
    end
    if (r.ms_div == 32'(MS_CYC - 1)) begin
      n.ms_div = '0;
      n.ms_tick = 1'b1;
      if (r.s_div == 32'(MS_PER_S - 1)) begin
        n.s_div = '0;
        n.s_tick = 1'b1;
      end else begin
        n.s_div = r.s_div + 32'h1;
      end
    end else begin
      n.ms_div = r.ms_div + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ms_tick = r.ms_tick;
  assign s_tick = r.s_tick;
  assign baud_tick = r.baud_tick;

endmodule : lpsw_tick
`default_nettype wire

//--- rtl/lpsw_top.sv
// Function
// - Try five seconds, then sleep 225 seconds
// - Later failures double the sleep time
// - After five failures wake 5s hourly
// - Standby holds request-to-send high
// - Awake with room drives request-to-send low
// - Idle timeout from request-to-send fall
// - Forced-wake high wakes the module
// - Sleep-state output high while operating
// - Serial rate fixed, no rate register
// - Two registers select low-power and wake
// - Register reports association status
// - Register selects radio centre frequency
// - Wake edges within one second merge
`timescale 1ns/100ps
`default_nettype none
`include "lpsw_cfg.svh"

module lpsw_top
  import lpsw_pkg::*;
#(
  parameter int MS_CYC = `LPSW_CLK_HZ / 1000 * `LPSW_TICK_MS,
  parameter int MS_PER_S = `LPSW_MS_PER_S,
  parameter int BAUD_CYC = `LPSW_CLK_HZ / `LPSW_BAUD_BPS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`LPSW_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic forced_wake,
  input wire logic wake_io,
  input wire logic rx_room,
  input wire logic rx_byte,
  input wire logic assoc_ok,
  input wire logic report_done,
  output logic uart_rts,
  output logic sleep_state_output,
  output logic assoc_try,
  output logic report_req,
  output logic [7:0] freq_sel,
  output logic baud_tick
);

  lpsw_core_s r, n;
  logic ms_tick;
  logic s_tick;
  logic lp_en;
  logic wake_f;
  logic io_edge;
  logic io_wake;
  logic idle_done;
  logic [`LPSW_IDX_W-1:0] wr_idx;
  logic [`LPSW_IDX_W-1:0] rd_idx;

  // Word index of a byte address
  function automatic logic [`LPSW_IDX_W-1:0] reg_index(input logic [`LPSW_ADDR_W-1:0] a);
    reg_index = a[`LPSW_ADDR_W-1:2];
  endfunction : reg_index

  lpsw_tick #(
    .MS_CYC(MS_CYC),
    .MS_PER_S(MS_PER_S),
    .BAUD_CYC(BAUD_CYC)
  ) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ms_tick(ms_tick),
    .s_tick(s_tick),
    .baud_tick(baud_tick)
  );

  assign wr_idx = reg_index(reg_addr);
  assign rd_idx = reg_index(reg_addr);
  assign lp_en = r.lp_sel[`LPSW_LP_EN_BIT];
  assign wake_f = r.wk_s2;
  assign io_edge = (r.edge_cfg[`LPSW_EDGE_RISE_BIT] & r.io_s2 & ~r.io_d) |
                   (r.edge_cfg[`LPSW_EDGE_FALL_BIT] & ~r.io_s2 & r.io_d);
  assign io_wake = io_edge && (r.lock_cnt == '0);
  assign idle_done = (r.ms_cnt >= r.idle_to);

  always_comb begin
    n = r;
    n.rdata = '0;

    // Wake pins pass two flops before use
    n.wk_s1 = forced_wake;
    n.wk_s2 = r.wk_s1;
    n.io_s1 = wake_io;
    n.io_s2 = r.io_s1;
    n.io_d = r.io_s2;

    if (io_wake) begin
      n.lock_cnt = `LPSW_IO_LOCK_MS;
    end else if (ms_tick && r.lock_cnt != '0) begin
      n.lock_cnt = r.lock_cnt - 10'h001;
    end

    unique case (r.st)
      ST_ASSOC: begin
        if (s_tick) begin
          n.sec_cnt = r.sec_cnt + 16'h0001;
        end
        if (assoc_ok) begin
          n.assoc = 1'b1;
          n.fails = '0;
          n.hourly = 1'b0;
          n.ms_cnt = '0;
          n.st = ST_AWAKE;
        end else if (lp_en && !wake_f && r.sec_cnt >= `LPSW_ASSOC_TRY_S) begin
          n.sec_cnt = '0;
          n.st = ST_BACKOFF;
          if (r.hourly) begin
            n.sec_tgt = `LPSW_HOUR_S - `LPSW_ASSOC_TRY_S;
          end else begin
            n.sec_tgt = `LPSW_BACKOFF_S << r.fails;
            n.fails = r.fails + 3'h1;
            if (r.fails + 3'h1 >= `LPSW_FAIL_LIMIT) begin
              n.hourly = 1'b1;
            end
          end
        end
      end
      ST_BACKOFF: begin
        if (s_tick) begin
          n.sec_cnt = r.sec_cnt + 16'h0001;
        end
        if (wake_f) begin
          n.ms_cnt = '0;
          n.st = ST_AWAKE;
        end else if (io_wake) begin
          n.st = ST_REPORT;
        end else if (!lp_en || r.sec_cnt >= r.sec_tgt) begin
          n.sec_cnt = '0;
          n.st = ST_ASSOC;
        end
      end
      ST_STANDBY: begin
        if (s_tick) begin
          n.sec_cnt = r.sec_cnt + 16'h0001;
        end
        if (wake_f || !lp_en) begin
          n.ms_cnt = '0;
          n.st = ST_AWAKE;
        end else if (io_wake) begin
          n.st = ST_REPORT;
        end else if (r.per_wake != '0 && r.sec_cnt >= r.per_wake) begin
          n.ms_cnt = '0;
          n.st = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        // timer restarts on fall and on each byte
        if (r.rts || rx_byte) begin
          n.ms_cnt = '0;
        end else if (ms_tick && !idle_done) begin
          n.ms_cnt = r.ms_cnt + 16'h0001;
        end
        if (lp_en && !wake_f && !r.rts && !rx_byte && idle_done) begin
          if (r.assoc) begin
            n.sec_cnt = '0;
            n.st = ST_STANDBY;
          end else begin
            n.st = ST_BACKOFF;
          end
        end
      end
      ST_REPORT: begin
        if (wake_f) begin
          n.ms_cnt = '0;
          n.st = ST_AWAKE;
        end else if (report_done) begin
          n.st = r.assoc ? ST_STANDBY : ST_BACKOFF;
        end
      end
    endcase

    n.awake = (n.st == ST_ASSOC) || (n.st == ST_AWAKE) || (n.st == ST_REPORT);
    n.rts = !(n.awake && rx_room);
    n.rpt = (n.st == ST_REPORT);
    n.try_assoc = (n.st == ST_ASSOC);

    // Register writes; status is read only
    if (reg_wr) begin
      unique case (wr_idx)
        `LPSW_IDX_LP_SELECT: n.lp_sel = reg_wdata[7:0];
        `LPSW_IDX_PER_WAKE: n.per_wake = reg_wdata[15:0];
        `LPSW_IDX_FREQ_SEL: n.freq = reg_wdata[7:0];
        `LPSW_IDX_IDLE_TO: n.idle_to = reg_wdata[15:0];
        `LPSW_IDX_EDGE_CFG: n.edge_cfg = reg_wdata[1:0];
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      unique case (rd_idx)
        `LPSW_IDX_LP_SELECT: n.rdata = {24'h000000, r.lp_sel};
        `LPSW_IDX_PER_WAKE: n.rdata = {16'h0000, r.per_wake};
        `LPSW_IDX_FREQ_SEL: n.rdata = {24'h000000, r.freq};
        `LPSW_IDX_IDLE_TO: n.rdata = {16'h0000, r.idle_to};
        `LPSW_IDX_EDGE_CFG: n.rdata = {30'h00000000, r.edge_cfg};
        `LPSW_IDX_ASSOC_STAT: n.rdata = {26'h0000000, r.fails, r.hourly, r.assoc, r.awake};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.st <= ST_ASSOC;
      r.lp_sel <= `LPSW_RST_LP_SELECT;
      r.per_wake <= `LPSW_RST_PER_WAKE;
      r.freq <= `LPSW_RST_FREQ_SEL;
      r.idle_to <= `LPSW_RST_IDLE_TO;
      r.edge_cfg <= `LPSW_RST_EDGE_CFG;
      r.rts <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign uart_rts = r.rts;
  assign sleep_state_output = r.awake;
  assign assoc_try = r.try_assoc;
  assign report_req = r.rpt;
  assign freq_sel = r.freq;

endmodule : lpsw_top
`default_nettype wire

//--- test/lpsw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpsw_host_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] gap,
  input wire logic [3:0] nbytes,
  input wire logic uart_rts,
  output logic forced_wake,
  output logic rx_byte,
  output logic done
);
  initial begin
    forced_wake = 1'h0;
    rx_byte = 1'h0;
    done = 1'h0;
    forever begin
      @(posedge ref_clk);
      if (go && !done) begin
        forced_wake <= 1'h1;
        for (int i = 0; i < nbytes; i++) begin
          repeat (gap) @(posedge ref_clk);
          while (uart_rts) @(posedge ref_clk);
          rx_byte <= 1'h1;
          @(posedge ref_clk);
          rx_byte <= 1'h0;
        end
        forced_wake <= 1'h0;
        done <= 1'h1;
      end else if (!go) begin
        done <= 1'h0;
      end
    end
  end
endmodule : lpsw_host_model
`default_nettype wire

//--- test/lpsw_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "lpsw_cfg.svh"
module lpsw_monitor #(
  parameter int MS_CYC = 25000,
  parameter int MS_PER_S = 1000,
  parameter int BAUD_CYC = 1302
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`LPSW_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic forced_wake,
  input wire logic rx_room,
  input wire logic assoc_ok,
  input wire logic uart_rts,
  input wire logic sleep_state_output,
  input wire logic assoc_try,
  input wire logic [7:0] freq_sel,
  input wire logic baud_tick
);
  // Second ticks run free, so attempt length is known to one second
  localparam int TRY_LO = 4 * MS_PER_S * MS_CYC;
  localparam int TRY_HI = 5 * MS_PER_S * MS_CYC + 4;
  logic [31:0] try_r;
  logic [31:0] bc_r;
  logic seen_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      try_r <= 32'h0;
      bc_r <= 32'h0;
      seen_r <= 1'h0;
    end else begin
      try_r <= assoc_try ? try_r + 32'h1 : 32'h0;
      bc_r <= baud_tick ? 32'h0 : bc_r + 32'h1;
      seen_r <= seen_r | baud_tick;
    end
  end
  sequence s_held;
    forced_wake [*6];
  endsequence
  sequence s_rd_stat;
    reg_rd && reg_addr == 12'h4B8;
  endsequence
  sequence s_freq_wr;
    reg_wr && reg_addr == 12'h4CC ##1 !(reg_wr && reg_addr == 12'h4CC);
  endsequence
  property p_rts_standby;
    !sleep_state_output |-> uart_rts;
  endproperty
  property p_rts_room;
    !$past(rx_room) |-> uart_rts;
  endproperty
  property p_rts_fall;
    $fell(uart_rts) |-> sleep_state_output;
  endproperty
  property p_forced;
    s_held |-> ##[0:3] sleep_state_output;
  endproperty
  property p_baud;
    baud_tick && seen_r |-> bc_r == BAUD_CYC - 1;
  endproperty
  property p_try_len;
    $fell(assoc_try) && !sleep_state_output && !$past(assoc_ok) |-> try_r inside {[TRY_LO:TRY_HI]};
  endproperty
  property p_status;
    s_rd_stat |=> reg_rdata[31:6] == 26'h0;
  endproperty
  property p_freq;
    s_freq_wr |=> freq_sel == $past(reg_wdata[7:0], 2);
  endproperty
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rts_standby: assert property (p_rts_standby) else $error("rts low in standby");
  a_rts_room: assert property (p_rts_room) else $error("rts low without room");
  a_rts_fall: assert property (p_rts_fall) else $error("rts fell while asleep");
  a_forced: assert property (p_forced) else $error("forced wake ignored");
  a_baud: assert property (p_baud) else $error("baud tick spacing wrong");
  a_try_len: assert property (p_try_len) else $error("attempt length wrong");
  a_status: assert property (p_status) else $error("status upper bits set");
  a_freq: assert property (p_freq) else $error("frequency not taken");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule : lpsw_monitor
bind lpsw_top lpsw_monitor #(.MS_CYC(MS_CYC), .MS_PER_S(MS_PER_S), .BAUD_CYC(BAUD_CYC)) u_lpsw_monitor (
  .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .forced_wake, .rx_room,
  .assoc_ok, .uart_rts, .sleep_state_output, .assoc_try, .freq_sel, .baud_tick);
`default_nettype wire

//--- test/test_low_power_serial_wake.sv
`timescale 1ns/100ps
`default_nettype none
module test_low_power_serial_wake;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} lpsw_row_s;
  lpsw_row_s rows [8] = '{
    '{1'h0, 12'h550, 32'h0, 32'h0}, '{1'h0, 12'h578, 32'h0, 32'h64},
    '{1'h1, 12'h550, 32'h1, 32'h1}, '{1'h1, 12'h4CC, 32'hA5, 32'hA5},
    '{1'h1, 12'h554, 32'h1234, 32'h1234}, '{1'h1, 12'h578, 32'hA, 32'hA},
    '{1'h1, 12'h57C, 32'h1, 32'h1}, '{1'h1, 12'h600, 32'hFF, 32'h0}};
  logic ref_clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, wake_io = 1'h0, rx_room = 1'h1;
  logic assoc_ok = 1'h0, report_done = 1'h0, go = 1'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [7:0] gap = 8'hC8;
  logic [3:0] nbytes = 4'h3;
  logic forced_wake, rx_byte, uart_rts, sso, assoc_try, report_req, hdone;
  int failures = 0, compares = 0, cyc = 0, n, lows;
  lpsw_top #(.MS_CYC(10), .MS_PER_S(5), .BAUD_CYC(1302)) u_lpsw_top (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .forced_wake, .wake_io,
    .rx_room, .rx_byte, .assoc_ok, .report_done, .uart_rts, .sleep_state_output(sso), .assoc_try,
    .report_req, .freq_sel(), .baud_tick());
  lpsw_host_model u_lpsw_host_model (.ref_clk, .go, .gap, .nbytes, .uart_rts, .forced_wake, .rx_byte,
    .done(hdone));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask : bus
  // Sampling 1 ns after the edge keeps clear of registered updates
  task automatic till(ref logic s, input logic want, input int lim, output int k);
    for (k = 0; k < lim && s !== want; k++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : till
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 70000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    chk(uart_rts, 1'h1);
    chk(sso, 1'h0);
    @(posedge ref_clk);
    rstn <= 1'h1;
    @(posedge ref_clk);
    #1;
    chk({assoc_try, sso, uart_rts}, 3'h6);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'h1, rows[i].a, rows[i].d);
      bus(1'h0, rows[i].a, 32'h0);
      chk(v, rows[i].e);
    end
    bus(1'h1, 12'h4B8, 32'hFFFFFFFF);
    bus(1'h0, 12'h4B8, 32'h0);
    chk(v & 32'hFFFFFFC0, 32'h0);
    till(assoc_try, 1'h0, 400, n);
    chk({sso, uart_rts}, 2'h1);
    till(assoc_try, 1'h1, 13000, n);
    chk(n >= 11150 && n <= 11300, 1'h1);
    till(assoc_try, 1'h0, 400, n);
    till(assoc_try, 1'h1, 23000, n);
    chk(n >= 22400 && n <= 22550, 1'h1);
    till(assoc_try, 1'h0, 400, n);
    @(posedge ref_clk);
    go <= 1'h1;
    till(sso, 1'h1, 10, n);
    chk(n <= 7, 1'h1);
    @(posedge ref_clk);
    rx_room <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk(uart_rts, 1'h1);
    @(posedge ref_clk);
    rx_room <= 1'h1;
    till(uart_rts, 1'h0, 4, n);
    chk(uart_rts, 1'h0);
    lows = 0;
    for (n = 0; n < 2000 && !hdone; n++) begin
      @(posedge ref_clk);
      #1 lows += !sso;
    end
    chk(lows, 0);
    till(sso, 1'h0, 300, n);
    chk(n >= 80 && n <= 115, 1'h1);
    @(posedge ref_clk);
    go <= 1'h0;
    wake_io <= 1'h1;
    till(report_req, 1'h1, 10, n);
    chk(report_req, 1'h1);
    @(posedge ref_clk);
    report_done <= 1'h1;
    wake_io <= 1'h0;
    repeat (3) @(posedge ref_clk);
    report_done <= 1'h0;
    wake_io <= 1'h1;
    till(report_req, 1'h1, 20, n);
    chk(report_req, 1'h0);
    @(posedge ref_clk);
    wake_io <= 1'h0;
    // Lockout is 1000 ms of 10-cycle ticks, so wait it out before the next edge
    repeat (10050) @(posedge ref_clk);
    wake_io <= 1'h1;
    till(report_req, 1'h1, 10, n);
    chk(report_req, 1'h1);
    results();
  end
endmodule : test_low_power_serial_wake
`default_nettype wire
